// ===== logic/imdr_diag.sv
// diagnostic record of a four channel digital input module, read by record set, index or subindex
//
// Function
// - record set 01h returns whole record; record set 00h returns first four bytes
// - canopen index 2F01h maps whole record; 2F00h maps first four bytes
// - ethercat index 5005h: subindex 02h..11h per byte, 13h timestamp
// - module info: class 1111b, channel info flag bit 4, reads 1Fh
// - channel type 70h digital input, bit 7 always zero
// - diagnostic bits per channel reads 00h
// - channel count reads 04h
// - record generation latches 32-bit microsecond ticker into timestamp, reset zero
// - no interrupts; record is read-only information
`timescale 1ns/10ps
`default_nettype none
module imdr_diag (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire imdr_pkg::imdr_req_t req,
  output logic req_ready,
  output imdr_pkg::imdr_rsp_t rsp,
  input wire logic [31:0] us_ticker,
  input wire logic record_gen
);
  import imdr_pkg::*;

  typedef enum logic [1:0] {
    IMDR_IDLE = 2'b00,
    IMDR_FETCH = 2'b01,
    IMDR_ANSWER = 2'b11
  } imdr_fsm_t;

  typedef struct packed {
    imdr_fsm_t fsm;
    logic [7:0] addr;
    logic err;
    logic [31:0] stamp;
  } imdr_state_t;

  imdr_state_t st;
  imdr_state_t next_st;
  logic take;
  logic [7:0] rom_data;
  logic dec_err;
  logic [7:0] dec_addr;
  logic [7:0] sub_off;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  assign take = req.valid && req_ready;

  always_comb begin
    dec_err = 1'b1;
    dec_addr = BYTE_RSVD_A;
    sub_off = req.sub - ECAT_SUB_FIRST;
    if (req.write) begin
      dec_err = 1'b1;
    end else if (req.space == IMDR_SPACE_RECORD_SET && req.index == RECORD_SET_FULL) begin
      dec_err = (req.sub >= 8'(REC_BYTES));
      dec_addr = req.sub;
    end else if (req.space == IMDR_SPACE_RECORD_SET && req.index == RECORD_SET_HEAD) begin
      dec_err = (req.sub >= 8'(HEAD_BYTES));
      dec_addr = req.sub;
    end else if (req.space == IMDR_SPACE_CANOPEN && req.index == CANOPEN_FULL) begin
      dec_err = (req.sub >= 8'(REC_BYTES));
      dec_addr = req.sub;
    end else if (req.space == IMDR_SPACE_CANOPEN && req.index == CANOPEN_HEAD) begin
      dec_err = (req.sub >= 8'(HEAD_BYTES));
      dec_addr = req.sub;
    end else if (req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX) begin
      if (req.sub >= ECAT_SUB_FIRST && req.sub <= ECAT_SUB_LAST) begin
        dec_err = 1'b0;
        dec_addr = sub_off;
      end else if (req.sub == ECAT_SUB_TS) begin
        dec_err = 1'b0;
        dec_addr = BYTE_TS_FIRST + {6'h00, req.byte_sel};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and snapshot

  always_comb begin
    next_st = st;
    if (record_gen) begin
      next_st.stamp = us_ticker;
    end
    case (st.fsm)
      IMDR_IDLE: begin
        if (take) begin
          next_st.fsm = IMDR_FETCH;
          // refused requests fetch a reserved byte, so the data output reads zero
          next_st.addr = dec_err ? BYTE_RSVD_A : dec_addr;
          next_st.err = dec_err;
        end
      end
      IMDR_FETCH: begin
        next_st.fsm = IMDR_ANSWER;
      end
      IMDR_ANSWER: begin
        next_st.fsm = IMDR_IDLE;
      end
      default: begin
        next_st.fsm = IMDR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st.fsm <= IMDR_IDLE;
      st.addr <= BYTE_RSVD_A;
      st.err <= 1'b0;
      st.stamp <= TIMESTAMP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // snapshot crosses into the rom only while fetching, so a mid-read strobe cannot tear bytes
  imdr_rom u_rom (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rd_en(st.fsm == IMDR_FETCH),
    .addr(st.addr),
    .stamp(st.stamp),
    .rd_data(rom_data)
  );

  // there is deliberately no interrupt output; answers only follow requests
  assign req_ready = (st.fsm == IMDR_IDLE);
  assign rsp.valid = (st.fsm == IMDR_ANSWER);
  assign rsp.err = st.err;
  assign rsp.data = rom_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_head_limit: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_RECORD_SET && req.index == RECORD_SET_HEAD
    && req.sub == 8'h04 |-> ##2 rsp.valid && rsp.err)
    else $error("record set 00h served beyond its head bytes");

  a_canopen_full: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_CANOPEN && req.index == CANOPEN_FULL
    && req.sub == 8'h06 |-> ##2 rsp.valid && !rsp.err && rsp.data == 8'h04)
    else $error("canopen full record byte 6 wrong");

  a_ecat_modinfo: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h03 |-> ##2 rsp.valid && !rsp.err && rsp.data == 8'h1F)
    else $error("ethercat subindex 03h not module info");

  a_ecat_type: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h06 |-> ##2 rsp.valid && rsp.data == 8'h70)
    else $error("channel type byte wrong");

  a_ecat_bits: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h07 |-> ##2 rsp.valid && !rsp.err && rsp.data == 8'h00)
    else $error("diagnostic bit count not zero");

  a_head_info: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_RECORD_SET && req.index == RECORD_SET_HEAD
    && req.sub == 8'h01 |-> ##2 rsp.valid && !rsp.err && rsp.data == 8'h1F)
    else $error("module info byte wrong");

  a_stamp_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h13 && req.byte_sel == 2'h0 && !record_gen
    |-> ##2 rsp.valid && rsp.data == $past(st.stamp[7:0], 2))
    else $error("timestamp byte does not follow snapshot");

  a_chan_count: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_RECORD_SET && req.index == RECORD_SET_FULL
    && req.sub == 8'h06 |-> ##2 rsp.valid && rsp.data == 8'h04)
    else $error("channel count wrong");

  a_answer_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
    rsp.valid |-> $past(take, 2) && !req_ready)
    else $error("answer without request");

  a_write_refused: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && req.write |-> ##2 rsp.valid && rsp.err && rsp.data == 8'h00)
    else $error("write not refused");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_RECORD_SET && req.index == RECORD_SET_FULL
    && req.sub == 8'h0A |-> ##2 rsp.valid && !rsp.err && rsp.data == 8'h00)
    else $error("reserved byte not zero");

  a_canopen_head: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_CANOPEN && req.index == CANOPEN_HEAD
    && req.sub == 8'h04 |-> ##2 rsp.valid && rsp.err && rsp.data == 8'h00)
    else $error("canopen head index served beyond its head bytes");

  a_ecat_gap: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h12 |-> ##2 rsp.valid && rsp.err && rsp.data == 8'h00)
    else $error("unmapped ethercat subindex answered");

  a_ecat_first: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h02 |-> ##2 rsp.valid && !rsp.err && rsp.data == 8'h00)
    else $error("first ethercat subindex not served");

  a_ecat_last: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h11 |-> ##2 rsp.valid && !rsp.err && rsp.data == 8'h00)
    else $error("last per channel byte not zero");

  a_stamp_top: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req.write && req.space == IMDR_SPACE_ECAT && req.index == ECAT_INDEX
    && req.sub == 8'h13 && req.byte_sel == 2'h3 && !record_gen
    |-> ##2 rsp.valid && !rsp.err && rsp.data == $past(st.stamp[31:24], 2))
    else $error("timestamp top byte does not follow snapshot");

  a_snapshot_latch: assert property (@(posedge ref_clk) disable iff (!rstn)
    record_gen |=> st.stamp == $past(us_ticker))
    else $error("snapshot missed the ticker value");

endmodule
`default_nettype wire

// ===== logic/imdr_pkg.sv
// shared constants, layout and carrier types of the input module diagnostic record
package imdr_pkg;

  localparam int unsigned REC_BYTES = 20;
  localparam int unsigned HEAD_BYTES = 4;

  // record byte positions
  localparam logic [7:0] BYTE_RSVD_A = 8'h00;
  localparam logic [7:0] BYTE_MODULE_INFO = 8'h01;
  localparam logic [7:0] BYTE_RSVD_C = 8'h02;
  localparam logic [7:0] BYTE_RSVD_D = 8'h03;
  localparam logic [7:0] BYTE_CHANNEL_TYPE = 8'h04;
  localparam logic [7:0] BYTE_DIAG_BITS = 8'h05;
  localparam logic [7:0] BYTE_CHANNEL_COUNT = 8'h06;
  localparam logic [7:0] BYTE_CH_ERR_SUM = 8'h07;
  localparam logic [7:0] BYTE_PER_CH_FIRST = 8'h08;
  localparam logic [7:0] BYTE_PER_CH_LAST = 8'h0F;
  localparam logic [7:0] BYTE_TS_FIRST = 8'h10;

  // module info layout: class in 3..0, channel info present in 4
  localparam logic [3:0] MODULE_CLASS_DIGITAL = 4'hF;
  localparam logic MODULE_CH_INFO_PRESENT = 1'b1;
  localparam logic [7:0] MODULE_INFO_RESET = {3'h0, MODULE_CH_INFO_PRESENT, MODULE_CLASS_DIGITAL};
  localparam logic [6:0] CHANNEL_TYPE_DIG_IN = 7'h70;
  localparam logic [7:0] CHANNEL_TYPE_RESET = {1'b0, CHANNEL_TYPE_DIG_IN};
  localparam logic [7:0] DIAG_BITS_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_COUNT_RESET = 8'h04;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic [31:0] TIMESTAMP_RESET = 32'h0000_0000;

  // access keys
  localparam logic [15:0] RECORD_SET_HEAD = 16'h0000;
  localparam logic [15:0] RECORD_SET_FULL = 16'h0001;
  localparam logic [15:0] CANOPEN_HEAD = 16'h2F00;
  localparam logic [15:0] CANOPEN_FULL = 16'h2F01;
  localparam logic [15:0] ECAT_INDEX = 16'h5005;
  localparam logic [7:0] ECAT_SUB_FIRST = 8'h02;
  localparam logic [7:0] ECAT_SUB_LAST = 8'h11;
  localparam logic [7:0] ECAT_SUB_TS = 8'h13;

  typedef enum logic [1:0] {
    IMDR_SPACE_RECORD_SET = 2'h0,
    IMDR_SPACE_CANOPEN = 2'h1,
    IMDR_SPACE_ECAT = 2'h2
  } imdr_space_t;

  typedef struct packed {
    logic valid;
    logic write;
    imdr_space_t space;
    logic [15:0] index;
    logic [7:0] sub;
    logic [1:0] byte_sel;
  } imdr_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } imdr_rsp_t;

endpackage

// ===== logic/imdr_rom.sv
// record byte image with registered read data
`timescale 1ns/10ps
`default_nettype none
module imdr_rom (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] stamp,
  output logic [7:0] rd_data
);
  import imdr_pkg::*;

  typedef struct packed {
    logic [7:0] data;
  } imdr_rom_state_t;

  imdr_rom_state_t st;
  imdr_rom_state_t next_st;
  logic [7:0] ts_off;

  always_comb begin
    next_st = st;
    ts_off = addr - BYTE_TS_FIRST;
    if (rd_en) begin
      if (addr == BYTE_MODULE_INFO) begin
        next_st.data = MODULE_INFO_RESET;
      end else if (addr == BYTE_CHANNEL_TYPE) begin
        next_st.data = CHANNEL_TYPE_RESET;
      end else if (addr == BYTE_DIAG_BITS) begin
        next_st.data = DIAG_BITS_RESET;
      end else if (addr == BYTE_CHANNEL_COUNT) begin
        next_st.data = CHANNEL_COUNT_RESET;
      end else if (addr >= BYTE_TS_FIRST) begin
        next_st.data = stamp[{ts_off[1:0], 3'h0} +: 8];
      end else begin
        // reserved error bytes never report anything
        next_st.data = RESERVED_VALUE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.data;

endmodule
`default_nettype wire

// ===== verification/imdr_head.sv
// head module model: microsecond ticker seen by the record snapshot
`timescale 1ns/10ps
`default_nettype none
module imdr_head (
  input wire logic ref_clk,
  input wire logic rstn,
  output logic [31:0] us_ticker
);
  //////////////////////////////////////////////////////////////////
  // steps once a cycle, not once a microsecond, to keep runs short
  // start value makes every byte of the ticker nonzero at reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      us_ticker <= 32'hA5C3_17F0;
    end else begin
      us_ticker <= us_ticker + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// ===== verification/input_module_diag_record_tb.sv
// self-checking bench of the diagnostic record against a behavioural model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module input_module_diag_record_tb;
  import imdr_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  imdr_req_t req = '0;
  logic req_ready;
  imdr_rsp_t rsp;
  logic [31:0] us_ticker;
  logic record_gen = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 32'h2ef3;
  int snap = 0;
  int i;
  int keys [8] = '{0, 1, 'h2F00, 'h2F01, 'h5005, 2, 'h2F02, 'h5006};
  //////////////////////////////////////////////////////////////////
  imdr_diag imdr_diag_i (.ref_clk(ref_clk), .rstn(rstn), .req(req), .req_ready(req_ready), .rsp(rsp),
    .us_ticker(us_ticker), .record_gen(record_gen));
  imdr_head imdr_head_i (.ref_clk(ref_clk), .rstn(rstn), .us_ticker(us_ticker));
  always #25 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////
  // expected {err, data}; err forces data to zero
  function automatic logic [8:0] model(int sp, int idx, int sb, int bs, int wr);
    int len;
    int off;
    len = 0;
    off = -1;
    if (sp == 0 && idx == 1 || sp == 1 && idx == 'h2F01) len = 20;
    if (sp == 0 && idx == 0 || sp == 1 && idx == 'h2F00) len = 4;
    if (sb < len) off = sb;
    if (sp == 2 && idx == 'h5005 && sb >= 2 && sb <= 'h11) off = sb - 2;
    if (sp == 2 && idx == 'h5005 && sb == 'h13) off = 16 + bs;
    if (wr != 0 || off < 0) return 9'h100;
    case (off)
      1: return 9'h01F;
      4: return 9'h070;
      6: return 9'h004;
      16, 17, 18, 19: return {1'b0, 8'(snap >> (8 * (off - 16)))};
      default: return 9'h000;
    endcase
  endfunction
  // one byte per request; ready and answer waits are bounded
  task automatic acc(int sp, int idx, int sb, int bs, int wr);
    logic [8:0] e;
    int k;
    e = model(sp, idx, sb, bs, wr);
    req.valid = 1'b1;
    req.write = wr[0];
    req.space = imdr_space_t'(sp[1:0]);
    req.index = idx[15:0];
    req.sub = sb[7:0];
    req.byte_sel = bs[1:0];
    for (k = 0; k < 4 && req_ready !== 1'b1; k++) @(negedge ref_clk);
    `CHK(req_ready, 1'b1)
    @(negedge ref_clk);
    req.valid = 1'b0;
    for (k = 0; k < 4 && rsp.valid !== 1'b1; k++) @(negedge ref_clk);
    `CHK(rsp.valid, 1'b1)
    `CHK({rsp.err, rsp.data}, e)
  endtask
  task automatic gen();
    record_gen = 1'b1;
    snap = us_ticker;
    @(negedge ref_clk);
    record_gen = 1'b0;
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    for (i = 0; i < 20; i++) begin
      acc(0, 1, i, 0, 0);
      acc(1, 'h2F01, i, 0, 0);
    end
    for (i = 0; i < 5; i++) begin
      acc(0, 0, i, 0, 0);
      acc(1, 'h2F00, i, 0, 0);
    end
    gen();
    for (i = 0; i < 24; i++) acc(2, 'h5005, i, i % 4, 0);
    for (i = 0; i < 4; i++) acc(2, 'h5005, 'h13, i, 0);
    for (i = 0; i < 3; i++) begin
      acc(i, keys[i + 1], i + 1, 0, 1);
      acc(i, keys[i + 1], i + 1, 0, 0);
    end
    // random mix, unknown keys and spaces included
    for (i = 0; i < 80; i++) begin
      if ($unsigned($random(seed)) % 4 == 0) gen();
      acc($unsigned($random(seed)) % 4, keys[$unsigned($random(seed)) % 8], $unsigned($random(seed)) % 24,
        $unsigned($random(seed)) % 4, ($unsigned($random(seed)) % 8) == 0);
    end
    report_and_stop();
  end
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule
`undef CHK
`default_nettype wire
